/* ppss_board.sv */
`timescale 1ns/1ns
module ppss_board (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // wanted strap levels
    input wire logic want_cell_i,
    input wire logic want_host_i,
    input wire logic want_ser2_i,
    input wire logic want_ai_i,
    // strap pins
    output logic cell_o,
    output logic host_o,
    output logic ser2_o,
    output logic ai_o
);
    // cell, host and autoinit resistors only change while the device is held in reset; serial2 follows at any time
    always_ff @(posedge mclk_i) begin
        if (rst_i) {cell_o, host_o, ai_o} <= {want_cell_i, want_host_i, want_ai_i};
        ser2_o <= want_ser2_i;
    end
endmodule // ppss_board

/* ppss_pin_share.sv */
`timescale 1ns/1ns
// Functional notes
// - latch cell select strap, pick cell or serial1
// - strap 0: serial1 on, cell pins high-z
// - strap 1: cell port on, serial1 pins high-z
// - latch host and serial2 straps, derive enables
// - host 0: host port, byte/eeprom pins high-z
// - host 1: host off, shared pins to pci
// - serial2 off only when host1 and serial2 0
// - eeprom autoinit when host1, serial2 0, strap 1
// - serial2 strap raised later: serial2 on, eeprom off
// - timers, serial0, gpio 8:0 always available
// - autoinit strap 0: pci uses default config
module ppss_pin_share
    import ppss_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // straps
    input wire logic cell_select_strap_pin_i,
    input wire logic host_select_strap_i,
    input wire logic serial2_select_strap_i,
    input wire logic autoinit_strap_pin_i,
    // gpio 15:9 software control
    input wire logic [GPIO_HI_W-1:0] gpio_pin_enable_bit_i,
    input wire logic [GPIO_HI_W-1:0] gpio_pin_direction_bit_i,
    // peripheral enables
    output logic cell_port_en_o,
    output logic serial_port1_en_o,
    output logic host_port_en_o,
    output logic pci_en_o,
    output logic eeprom_en_o,
    output logic serial_port2_en_o,
    output logic serial_port0_en_o,
    output logic timers_en_o,
    output logic [GPIO_LO_W-1:0] gpio_lo_avail_o,
    // pin output enables, low while driving
    output logic cell_only_oe_n_o,
    output logic serial1_only_oe_n_o,
    output logic byte_enable0_oe_n_o,
    output logic eeprom_select_oe_n_o,
    output logic [GPIO_HI_W-1:0] gpio_hi_oe_n_o,
    // pci configuration
    output logic pci_autoinit_o,
    output ppss_cfg_src_type pci_cfg_src_o
);
    // ****************************************
    // strap capture
    // ****************************************
    logic cell_port_select_strap;
    logic host_strap;
    logic autoinit_strap;
    logic ser2_reset_strap;
    logic ser2_live;

    ppss_sync_strap u_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .strap_i(cell_select_strap_pin_i),
        .latched_o(cell_port_select_strap)
    );

    ppss_sync_strap u_host (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .strap_i(host_select_strap_i),
        .latched_o(host_strap)
    );

    ppss_sync_strap u_ser2 (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .strap_i(serial2_select_strap_i),
        .latched_o(ser2_reset_strap)
    );

    ppss_sync_strap u_aint (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .strap_i(autoinit_strap_pin_i),
        .latched_o(autoinit_strap)
    );

    // serial2 select is tracked live; inputs are synchronous, no synchroniser
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ser2_live <= SER2_STRAP_RST;
        end else begin
            ser2_live <= serial2_select_strap_i;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    // a strap selects its option when it sits at that option's level
    function automatic logic strap_is(input logic strap, input logic level);
        return strap == level;
    endfunction

    // an owned pin drives; a pin without an owner floats
    function automatic logic pin_oe_n(input logic owned);
        return !owned;
    endfunction

    wire cell_sel = strap_is(cell_port_select_strap, SEL_CELL_PORT);
    wire pci_sel = strap_is(host_strap, SEL_PCI);
    wire ser2_sel = strap_is(ser2_live, SER2_FORCE_ON);
    // eeprom only owns the port while serial2 is deselected
    wire eeprom_sel = pci_sel && !ser2_sel;
    // serial2 must be off at reset and still off now; raising it later drops the load
    wire autoinit_sel = eeprom_sel && !strap_is(ser2_reset_strap, SER2_FORCE_ON)
        && strap_is(autoinit_strap, AUTOINIT_ON);
    wire [GPIO_HI_W-1:0] gpio_drive = pci_sel ? '0 : (gpio_pin_enable_bit_i & gpio_pin_direction_bit_i);
    wire ppss_cfg_src_type next_cfg = !pci_sel ? ppss_cfg_none_type_e :
        (autoinit_sel ? ppss_cfg_eeprom_e : ppss_cfg_default_e);

    // ****************************************
    // next output values
    // ****************************************
    wire next_cell_en = cell_sel;
    wire next_serial1_en = !cell_sel;
    wire next_cell_oe_n = pin_oe_n(cell_sel);
    wire next_serial1_oe_n = pin_oe_n(!cell_sel);
    wire next_host_en = !pci_sel;
    wire next_pci_en = pci_sel;
    wire next_byte_enable0_oe_n = pin_oe_n(pci_sel);
    wire next_eeprom_select_oe_n = pin_oe_n(eeprom_sel);
    wire next_eeprom_en = eeprom_sel;
    // serial2 is the default owner of its port; only the eeprom can take it away
    wire next_serial2_en = !eeprom_sel;
    wire [GPIO_HI_W-1:0] next_gpio_hi_oe_n = ~gpio_drive;
    wire next_autoinit = autoinit_sel;

    // ****************************************
    // cell port and serial1
    // ****************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cell_port_en_o <= 1'h0;
            serial_port1_en_o <= 1'h0;
        end else begin
            cell_port_en_o <= next_cell_en;
            serial_port1_en_o <= next_serial1_en;
        end
    end

    // every shared pin floats while reset holds, before any owner is known
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cell_only_oe_n_o <= 1'h1;
            serial1_only_oe_n_o <= 1'h1;
        end else begin
            cell_only_oe_n_o <= next_cell_oe_n;
            serial1_only_oe_n_o <= next_serial1_oe_n;
        end
    end

    // ****************************************
    // host port, pci and eeprom
    // ****************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            host_port_en_o <= 1'h0;
            pci_en_o <= 1'h0;
        end else begin
            host_port_en_o <= next_host_en;
            pci_en_o <= next_pci_en;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_enable0_oe_n_o <= 1'h1;
            eeprom_select_oe_n_o <= 1'h1;
        end else begin
            byte_enable0_oe_n_o <= next_byte_enable0_oe_n;
            eeprom_select_oe_n_o <= next_eeprom_select_oe_n;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            eeprom_en_o <= 1'h0;
            serial_port2_en_o <= 1'h0;
        end else begin
            eeprom_en_o <= next_eeprom_en;
            serial_port2_en_o <= next_serial2_en;
        end
    end

    // ****************************************
    // general-purpose pins and fixed peripherals
    // ****************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gpio_hi_oe_n_o <= GPIO_HI_OFF;
        end else begin
            gpio_hi_oe_n_o <= next_gpio_hi_oe_n;
        end
    end

    // fixed peripherals never lose their pins, whatever the straps say
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_port0_en_o <= 1'h0;
            timers_en_o <= 1'h0;
            gpio_lo_avail_o <= '0;
        end else begin
            serial_port0_en_o <= 1'h1;
            timers_en_o <= 1'h1;
            gpio_lo_avail_o <= '1;
        end
    end

    // ****************************************
    // pci configuration source
    // ****************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pci_autoinit_o <= 1'h0;
            pci_cfg_src_o <= ppss_cfg_none_type_e;
        end else begin
            pci_autoinit_o <= next_autoinit;
            pci_cfg_src_o <= next_cfg;
        end
    end
endmodule // ppss_pin_share

/* ppss_pkg.sv */
package ppss_pkg;
    // ****************************************
    // strap reset values and decode levels
    // ****************************************
    localparam logic CELL_STRAP_RST = 1'h0;
    localparam logic HOST_STRAP_RST = 1'h0;
    localparam logic SER2_STRAP_RST = 1'h0;
    localparam logic AUTOINIT_STRAP_RST = 1'h0;
    localparam logic SEL_CELL_PORT = 1'h1;
    localparam logic SEL_PCI = 1'h1;
    localparam logic SER2_FORCE_ON = 1'h1;
    localparam logic AUTOINIT_ON = 1'h1;
    // ****************************************
    // pin group widths
    // ****************************************
    localparam int GPIO_HI_W = 7;
    localparam int GPIO_LO_W = 9;
    localparam logic [GPIO_HI_W-1:0] GPIO_HI_OFF = 7'h7F;
    // ****************************************
    // pci configuration source
    // ****************************************
    typedef enum logic [1:0] {
        ppss_cfg_none_type_e,
        ppss_cfg_default_e,
        ppss_cfg_eeprom_e
    } ppss_cfg_src_type;
endpackage

/* ppss_sva.sv */
`timescale 1ns/1ns
module ppss_sva
    import ppss_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic serial2_select_strap_i,
    input wire logic [GPIO_HI_W-1:0] gpio_pin_enable_bit_i,
    input wire logic [GPIO_HI_W-1:0] gpio_pin_direction_bit_i,
    // peripheral enables
    input wire logic cell_port_en_o,
    input wire logic serial_port1_en_o,
    input wire logic host_port_en_o,
    input wire logic pci_en_o,
    input wire logic eeprom_en_o,
    input wire logic serial_port2_en_o,
    input wire logic serial_port0_en_o,
    input wire logic timers_en_o,
    input wire logic [GPIO_LO_W-1:0] gpio_lo_avail_o,
    // pin output enables
    input wire logic cell_only_oe_n_o,
    input wire logic serial1_only_oe_n_o,
    input wire logic byte_enable0_oe_n_o,
    input wire logic eeprom_select_oe_n_o,
    input wire logic [GPIO_HI_W-1:0] gpio_hi_oe_n_o,
    // pci configuration
    input wire logic pci_autoinit_o,
    input wire ppss_cfg_src_type pci_cfg_src_o
);
    // outputs settle two edges after release; wait three to be safe
    logic [1:0] age;
    wire ok = age == 2'h3;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) age <= 2'h0;
        else if (!ok) age <= age + 2'h1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_cell_pick: assert property (ok |-> cell_port_en_o != serial_port1_en_o)
        else $error("cell and serial1 not exclusive");
    chk_cell_hiz: assert property (ok |->
        cell_only_oe_n_o == serial_port1_en_o && serial1_only_oe_n_o == cell_port_en_o)
        else $error("cell or serial1 pin enable wrong");
    chk_host_pci: assert property (ok |->
        host_port_en_o != pci_en_o && byte_enable0_oe_n_o == host_port_en_o)
        else $error("host or pci selection wrong");
    chk_ser2_live: assert property (ok |->
        serial_port2_en_o == !(pci_en_o && !$past(serial2_select_strap_i, 2)))
        else $error("serial2 enable wrong");
    chk_eeprom_off: assert property (ok |->
        eeprom_en_o == !serial_port2_en_o && eeprom_select_oe_n_o == !eeprom_en_o)
        else $error("eeprom enable wrong");
    chk_always_on: assert property (ok |-> serial_port0_en_o && timers_en_o && (&gpio_lo_avail_o))
        else $error("fixed peripherals not available");
    chk_gpio_oe: assert property (ok |-> gpio_hi_oe_n_o ==
        (pci_en_o ? GPIO_HI_OFF : ~($past(gpio_pin_enable_bit_i) & $past(gpio_pin_direction_bit_i))))
        else $error("gpio high pin enable wrong");
    chk_strap_hold: assert property (ok |-> $stable(cell_port_en_o) && $stable(pci_en_o))
        else $error("latched selection changed");
    chk_autoinit: assert property (ok && pci_autoinit_o |-> pci_en_o && eeprom_en_o)
        else $error("autoinit outside pci eeprom mode");
    chk_cfg_none: assert property (ok |-> (pci_cfg_src_o == ppss_cfg_none_type_e) == !pci_en_o)
        else $error("pci config source wrong");
    cover property (ok && pci_autoinit_o);
    cover property (ok && cell_port_en_o);
    cover property (ok && $rose(serial_port2_en_o));
endmodule // ppss_sva

/* ppss_sync_strap.sv */
`timescale 1ns/1ns
module ppss_sync_strap
    import ppss_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // strap
    input wire logic strap_i,
    output logic latched_o
);
    logic in_reset;

    // in_reset is set while reset holds and clears on the first edge after its release
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            in_reset <= 1'h1;
        end else begin
            in_reset <= 1'h0;
        end
    end

    // first clean edge after release takes the strap once
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            latched_o <= 1'h0;
        end else if (in_reset) begin
            latched_o <= strap_i;
        end
    end
endmodule // ppss_sync_strap

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
    import ppss_pkg::*;
    logic mclk_i = 1'h0, rst_i = 1'h1, chk = 1'h0, wc = 1'h0, wh = 1'h0, ws = 1'h0, wa = 1'h0;
    logic [6:0] gpio_pin_enable_bit_i = 7'h0, gpio_pin_direction_bit_i = 7'h0;
    wire cell_select_strap_pin_i, host_select_strap_i, serial2_select_strap_i, autoinit_strap_pin_i;
    wire [30:0] o;
    logic [30:0] q[$], n;
    int bad_count = 0, check_count = 0;
    initial forever #25 mclk_i = !mclk_i;
    ppss_board u_ppss_board (.mclk_i, .rst_i, .want_cell_i(wc), .want_host_i(wh), .want_ser2_i(ws),
        .want_ai_i(wa), .cell_o(cell_select_strap_pin_i), .host_o(host_select_strap_i),
        .ser2_o(serial2_select_strap_i), .ai_o(autoinit_strap_pin_i));
    ppss_pin_share u_ppss_pin_share (.mclk_i, .rst_i, .cell_select_strap_pin_i, .host_select_strap_i,
        .serial2_select_strap_i, .autoinit_strap_pin_i, .gpio_pin_enable_bit_i, .gpio_pin_direction_bit_i,
        .cell_port_en_o(o[30]), .serial_port1_en_o(o[29]),
        .host_port_en_o(o[28]), .pci_en_o(o[27]), .eeprom_en_o(o[26]), .serial_port2_en_o(o[25]),
        .serial_port0_en_o(o[24]), .timers_en_o(o[23]), .gpio_lo_avail_o(o[22:14]),
        .cell_only_oe_n_o(o[13]), .serial1_only_oe_n_o(o[12]), .byte_enable0_oe_n_o(o[11]),
        .eeprom_select_oe_n_o(o[10]), .gpio_hi_oe_n_o(o[9:3]), .pci_autoinit_o(o[2]), .pci_cfg_src_o(o[1:0]));
    // r is serial2 as latched at reset, s its live level
    function automatic logic [30:0] exp_f(logic c, h, s, r, a, logic [6:0] e, d);
        logic ee;
        logic ai;
        ee = h & !s;
        ai = ee & !r & a;
        return {c, !c, !h, h, ee, !ee, 2'h3, 9'h1FF, !c, c, !h, !ee, h ? 7'h7F : ~(e & d), ai,
            h ? (ai ? 2'h2 : 2'h1) : 2'h0};
    endfunction
    task automatic check(logic [30:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic note(logic r);
        q.push_back(exp_f(wc, wh, ws, r, wa, gpio_pin_enable_bit_i, gpio_pin_direction_bit_i));
        chk <= 1'h1;
        @(posedge mclk_i);
        chk <= 1'h0;
    endtask
    // outputs are settled by the falling edge, so they are sampled there
    always @(negedge mclk_i) if (chk === 1'h1) begin
        if (q.size() == 0) begin
            bad_count++;
            $display("Error %0t no expected result queued", $time);
        end else begin
            n = q.pop_front();
            check(o, n);
        end
    end
    initial begin
        void'($urandom(32'h66CA));
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_i);
            rst_i <= 1'h1;
            {wc, wh, ws, wa} <= 4'(i);
            gpio_pin_enable_bit_i <= 7'($urandom);
            gpio_pin_direction_bit_i <= 7'($urandom);
            repeat (2) @(posedge mclk_i);
            rst_i <= 1'h0;
            repeat (4) @(posedge mclk_i);
            note(ws);
            ws <= !ws;
            gpio_pin_enable_bit_i <= 7'($urandom);
            repeat (4) @(posedge mclk_i);
            note(!ws);
        end
        conclude();
    end
    initial begin
        #100000;
        bad_count++;
        $display("Error %0t run limit reached", $time);
        conclude();
    end
endmodule // testbench
bind ppss_pin_share ppss_sva u_ppss_sva (.mclk_i, .rst_i, .serial2_select_strap_i, .gpio_pin_enable_bit_i,
    .gpio_pin_direction_bit_i, .cell_port_en_o, .serial_port1_en_o, .host_port_en_o, .pci_en_o, .eeprom_en_o,
    .serial_port2_en_o, .serial_port0_en_o, .timers_en_o, .gpio_lo_avail_o, .cell_only_oe_n_o,
    .serial1_only_oe_n_o, .byte_enable0_oe_n_o, .eeprom_select_oe_n_o, .gpio_hi_oe_n_o, .pci_autoinit_o,
    .pci_cfg_src_o);
